/* File: rtl/dec_exec_pkg.sv */
package dec_exec_pkg;
    // Opcode patterns (top six bits)
    localparam logic [5:0] OPC_DEC = 6'h01;
    localparam logic [5:0] OPC_DEC_SKIP = 6'h0B;
    localparam int OPC_MSB = 15;
    localparam int OPC_LSB = 10;
    localparam int DEST_BIT = 9;
    localparam int ACCESS_BIT = 8;
    // Access bank split and indexed literal offset limit
    localparam logic [7:0] ACCESS_LOW_LIMIT = 8'h5F;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    // Status flag positions
    localparam int FLAG_C = 0;
    localparam int FLAG_HALF_CARRY = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_SIGNED_WRAP = 3;
    localparam int FLAG_N = 4;
    localparam logic [4:0] STATUS_RESET = 5'h00;
    localparam logic [7:0] WREG_RESET = 8'h00;
    localparam logic [3:0] BANK_RESET = 4'h0;

    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } phase_e;

    // Top-nibble prefixes that mark the first word of a two-word instruction (1100 and 1110)
    localparam logic [3:0] OPC_TWO_WORD_A = 4'hC;
    localparam logic [3:0] OPC_TWO_WORD_B = 4'hE;
endpackage : dec_exec_pkg

/* File: rtl/dec_address_gen.sv */
`timescale 1ns/1ns
module dec_address_gen (
    // Instruction fields
    input wire logic [7:0] fileAddr,
    input wire logic accessBit,
    input wire logic extendedSet,
    // Banking state
    input wire logic [3:0] bank_select_reg,
    input wire logic [11:0] indexBase,
    // Result
    output logic [11:0] dataAddr,
    output logic indexedMode
);
    import dec_exec_pkg::*;

    wire logic lowAccess;
    wire logic [11:0] accessAddr;
    wire logic [11:0] bankAddr;
    wire logic [11:0] indexAddr;

    assign lowAccess = (fileAddr <= ACCESS_LOW_LIMIT);
    // Access bank: low part of bank 0, upper part maps to the top bank
    assign accessAddr = lowAccess ? {ACCESS_LOW_BANK, fileAddr} : {ACCESS_HIGH_BANK, fileAddr};
    assign bankAddr = {bank_select_reg, fileAddr};
    assign indexAddr = indexBase + {4'h0, fileAddr};
    assign indexedMode = !accessBit && extendedSet && lowAccess;
    assign dataAddr = accessBit ? bankAddr : (indexedMode ? indexAddr : accessAddr);
endmodule : dec_address_gen

/* File: rtl/decrement_instruction_exec.sv */
`timescale 1ns/1ns
module decrement_instruction_exec (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Instruction stream
    input wire logic [15:0] instrWord,
    input wire logic instrValid,
    input wire logic extendedSet,
    // Banking state
    input wire logic [3:0] bank_select_reg,
    input wire logic [11:0] indexBase,
    // Data memory
    output logic [11:0] memAddr,
    output logic memRead,
    input wire logic [7:0] memRdata,
    output logic memWrite,
    output logic [7:0] memWdata,
    // Core state
    output logic [7:0] wreg,
    output logic [4:0] status,
    output dec_exec_pkg::phase_e phase,
    output logic busy,
    output logic skipActive,
    output logic indexedMode
);
    import dec_exec_pkg::*;

    phase_e phase_q;
    logic [15:0] instr_q;
    logic active_q;
    logic [7:0] operand_q;
    logic [7:0] result_q;
    logic [4:0] status_q;
    logic [7:0] wreg_q;
    logic [1:0] skipCount_q;
    logic [1:0] skipCount_d;
    logic skipPend_q;
    logic [11:0] addr_q;
    logic memRead_q;
    logic memWrite_q;

    function automatic logic is_two_word(input logic [15:0] w);
        is_two_word = (w[15:12] == OPC_TWO_WORD_A) || (w[15:12] == OPC_TWO_WORD_B);
    endfunction : is_two_word

    // Places each flag at its status position
    function automatic logic [4:0] pack_flags(input logic carry, input logic halfCarry, input logic zero,
        input logic signedWrap, input logic negative);
        pack_flags = STATUS_RESET;
        pack_flags[FLAG_C] = carry;
        pack_flags[FLAG_HALF_CARRY] = halfCarry;
        pack_flags[FLAG_Z] = zero;
        pack_flags[FLAG_SIGNED_WRAP] = signedWrap;
        pack_flags[FLAG_N] = negative;
    endfunction : pack_flags

    wire logic [5:0] opcode;
    wire logic isDec;
    wire logic isDecSkip;
    wire logic [15:0] addrWord;
    wire logic [11:0] dataAddr;
    wire logic [7:0] diff;
    wire logic newCarry;
    wire logic newHalfCarry;
    wire logic newSignedWrap;
    wire logic newZero;
    wire logic newNegative;
    wire logic [4:0] newFlags;
    wire logic take;
    wire logic skipping;
    wire logic execRead;
    wire logic execCompute;
    wire logic lastPhase;
    wire logic skipLoad;
    wire logic skipStep;
    wire logic [1:0] flushCycles;

    // Instruction decode
    assign opcode = instrWord[OPC_MSB:OPC_LSB];
    assign isDec = instr_q[OPC_MSB:OPC_LSB] == OPC_DEC;
    assign isDecSkip = instr_q[OPC_MSB:OPC_LSB] == OPC_DEC_SKIP;
    assign skipping = skipCount_q != 2'd0;
    // Accept a new word at Q1 unless a skip is flushing
    assign take = (phase_q == PH_Q1) && instrValid && !skipping
        && ((opcode == OPC_DEC) || (opcode == OPC_DEC_SKIP));

    // Phase qualifiers of the executing instruction
    assign execRead = active_q && (phase_q == PH_Q2);
    assign execCompute = active_q && (phase_q == PH_Q3);
    assign lastPhase = phase_q == PH_Q4;

    // Address comes from the word being taken, so it stands for the whole read phase
    assign addrWord = take ? instrWord : instr_q;

    dec_address_gen addrGen (
        .fileAddr(addrWord[7:0]),
        .accessBit(addrWord[ACCESS_BIT]),
        .extendedSet(extendedSet),
        .bank_select_reg(bank_select_reg),
        .indexBase(indexBase),
        .dataAddr(dataAddr),
        .indexedMode(indexedMode)
    );

    // Subtract one; carry and half carry mean no borrow out of bit 7 and bit 3
    assign diff = operand_q - 8'h01;
    assign newCarry = operand_q != 8'h00;
    assign newHalfCarry = operand_q[3:0] != 4'h0;
    assign newSignedWrap = operand_q == 8'h80;
    assign newZero = diff == 8'h00;
    assign newNegative = diff[7];
    assign newFlags = pack_flags(newCarry, newHalfCarry, newZero, newSignedWrap, newNegative);

    // A taken skip flushes one cycle, two when the discarded word is a two-word instruction
    assign skipLoad = lastPhase && skipPend_q;
    assign skipStep = lastPhase && skipping;
    assign flushCycles = (instrValid && is_two_word(instrWord)) ? 2'd2 : 2'd1;

    always_comb begin
        skipCount_d = skipCount_q;
        if (skipLoad) begin
            skipCount_d = flushCycles;
        end else if (skipStep) begin
            skipCount_d = skipCount_q - 2'd1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= PH_Q1;
        end else begin
            phase_q <= phase_e'(phase_q + 2'b01);
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            instr_q <= 16'h0000;
            active_q <= 1'b0;
        end else if (take) begin
            instr_q <= instrWord;
            active_q <= 1'b1;
        end else if (lastPhase) begin
            active_q <= 1'b0;
        end
    end

    // Read strobe launches on the taking edge and stands for Q2 only
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            memRead_q <= 1'b0;
        end else begin
            memRead_q <= take;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            addr_q <= 12'h000;
        end else if (take) begin
            addr_q <= dataAddr;
        end
    end

    // Operand is sampled as Q2 ends
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            operand_q <= 8'h00;
        end else if (execRead) begin
            operand_q <= memRdata;
        end
    end

    // Result doubles as the write data for the file register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            result_q <= 8'h00;
        end else if (execCompute) begin
            result_q <= diff;
        end
    end

    // Only the plain decrement touches the flags
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            status_q <= STATUS_RESET;
        end else if (execCompute && isDec) begin
            status_q <= newFlags;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            skipPend_q <= 1'b0;
        end else if (execCompute) begin
            skipPend_q <= isDecSkip && newZero;
        end else if (lastPhase) begin
            skipPend_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            skipCount_q <= 2'd0;
        end else begin
            skipCount_q <= skipCount_d;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            memWrite_q <= 1'b0;
        end else begin
            memWrite_q <= execCompute && instr_q[DEST_BIT];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wreg_q <= WREG_RESET;
        end else if (execCompute && !instr_q[DEST_BIT]) begin
            wreg_q <= diff;
        end
    end

    assign memAddr = addr_q;
    assign memRead = memRead_q;
    assign memWrite = memWrite_q;
    assign memWdata = result_q;
    assign wreg = wreg_q;
    assign status = status_q;
    assign phase = phase_q;
    assign busy = active_q;
    assign skipActive = skipping;
endmodule : decrement_instruction_exec

/* File: bench/dec_exec_checker.sv */
`timescale 1ns/1ns
module dec_exec_checker
    import dec_exec_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Instruction and banking
    input wire logic [15:0] instrWord,
    input wire logic instrValid,
    input wire logic extendedSet,
    input wire logic [3:0] bank_select_reg,
    input wire logic [11:0] indexBase,
    // Data memory and core state
    input wire logic [7:0] memRdata,
    input wire logic [11:0] memAddr,
    input wire logic memRead,
    input wire logic memWrite,
    input wire logic [7:0] memWdata,
    input wire logic [4:0] status,
    input wire dec_exec_pkg::phase_e phase,
    input wire logic busy,
    input wire logic skipActive
);
    logic taken;
    logic lowAcc;
    assign taken = phase == PH_Q1 && instrValid && !skipActive
        && (instrWord[15:10] == OPC_DEC || instrWord[15:10] == OPC_DEC_SKIP);
    assign lowAcc = taken && !instrWord[8];
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    property p_read; taken |=> memRead && busy; endproperty
    a_read: assert property (p_read) else $error("no read in Q2");
    property p_wr; taken |-> ##3 memWrite == $past(instrWord[9], 3); endproperty
    a_wr: assert property (p_wr) else $error("bad write strobe");
    property p_wdata; taken && instrWord[9] |-> ##3 memWdata == 8'($past(memRdata, 2) - 8'h01); endproperty
    a_wdata: assert property (p_wdata) else $error("bad write data");
    property p_bank; taken && instrWord[8] |=> memAddr == {$past(bank_select_reg), $past(instrWord[7:0])}; endproperty
    a_bank: assert property (p_bank) else $error("bad banked address");
    property p_access; lowAcc && !extendedSet |=> memAddr[7:0] == $past(instrWord[7:0]); endproperty
    a_access: assert property (p_access) else $error("bad access address");
    property p_idx; lowAcc && extendedSet && instrWord[7:0] <= ACCESS_LOW_LIMIT
        |=> memAddr == 12'($past(indexBase) + $past(instrWord[7:0])); endproperty
    a_idx: assert property (p_idx) else $error("bad indexed address");
    property p_keep; taken && instrWord[15:10] == OPC_DEC_SKIP |=> $stable(status) [*4]; endproperty
    a_keep: assert property (p_keep) else $error("flags changed");
    property p_phase; phase == PH_Q4 |=> phase == PH_Q1 ##1 phase == PH_Q2; endproperty
    a_phase: assert property (p_phase) else $error("bad phase order");
    property p_flush; skipActive && phase == PH_Q1 |=> !memRead && !busy; endproperty
    a_flush: assert property (p_flush) else $error("word taken while flushing");
endmodule : dec_exec_checker
bind decrement_instruction_exec dec_exec_checker i_chk (.*);

/* File: bench/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
    import dec_exec_pkg::*;
    logic clock = 0, reset_n = 0, instrValid = 0, extendedSet = 0;
    logic [15:0] instrWord = 16'h0000;
    logic [3:0] bank_select_reg = 4'h3;
    logic [11:0] indexBase = 12'h100, memAddr;
    logic [7:0] memRdata = 8'h00, memWdata, wreg;
    logic memRead, memWrite, busy, skipActive, indexedMode;
    logic [4:0] status;
    phase_e phase;
    int num_errors = 0, samples_checked = 0;
    always #25 clock = ~clock;
    decrement_instruction_exec i_dut (.*);
    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask : chk
    // One instruction cycle from Q1 to Q4, leaving nxt on the bus for the skip look-ahead
    task automatic run(input logic [15:0] iw, input logic [7:0] op, input logic [15:0] nxt,
        input logic [11:0] eAddr, input logic [7:0] eW, input logic [4:0] eSt);
        while (phase !== PH_Q1) @(negedge clock);
        instrWord = iw;
        instrValid = 1;
        memRdata = op;
        @(negedge clock);
        instrValid = 0;
        chk("memRead", 12'h001, memRead);
        chk("memAddr", eAddr, memAddr);
        chk("indexedMode", !iw[8] && extendedSet && iw[7:0] <= ACCESS_LOW_LIMIT, indexedMode);
        repeat (2) @(negedge clock);
        chk("memWrite", iw[9], memWrite);
        if (iw[9]) chk("memWdata", 8'(op - 8'h01), memWdata);
        chk("wreg", eW, wreg);
        chk("status", eSt, status);
        instrWord = nxt;
        instrValid = 1;
    endtask : run
    task automatic test_dec(input logic [15:0] iw, input logic [11:0] eAddr, input logic [7:0] op,
        input logic [4:0] eSt);
        run(iw, op, 16'h0000, eAddr, 8'h00, eSt);
        $display("test_dec %h done", iw);
    endtask : test_dec
    task automatic test_skip(input logic [15:0] nxt, input int n);
        run({OPC_DEC_SKIP, 2'h3, 8'h21}, 8'h01, nxt, 12'h321, 8'h00, 5'h09);
        @(negedge clock);
        chk("skipActive", 12'h001, skipActive);
        instrWord = {OPC_DEC, 2'h3, 8'h21};
        instrValid = 1;
        @(negedge clock);
        chk("memRead", 12'h000, memRead);
        instrValid = 0;
        repeat (4 * n - 1) @(negedge clock);
        chk("skipActive", 12'h000, skipActive);
        $display("test_skip %0d done", n);
    endtask : test_skip
    task automatic test_noskip;
        run({OPC_DEC_SKIP, 2'h1, 8'h21}, 8'h05, 16'h0000, 12'h321, 8'h04, 5'h09);
        @(negedge clock);
        chk("skipActive", 12'h000, skipActive);
        $display("test_noskip done");
    endtask : test_noskip
    task automatic end_of_test;
        $display("Checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (2000) @(posedge clock);
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (6) @(posedge clock);
        @(negedge clock) reset_n = 1;
        test_dec({OPC_DEC, 2'h1, 8'h21}, 12'h321, 8'h01, 5'h07);
        test_dec({OPC_DEC, 2'h2, 8'h80}, 12'hF80, 8'h80, 5'h09);
        test_dec({OPC_DEC, 2'h2, 8'h10}, 12'h010, 8'h10, 5'h01);
        extendedSet = 1;
        test_dec({OPC_DEC, 2'h2, 8'h5F}, 12'h15F, 8'h80, 5'h09);
        test_dec({OPC_DEC, 2'h2, 8'h60}, 12'hF60, 8'h80, 5'h09);
        extendedSet = 0;
        test_skip(16'h0000, 1);
        test_skip(16'hC000, 2);
        test_noskip();
        end_of_test();
    end
endmodule : tb_top
